// ---- hw/hmsi_pkg.sv ----
package hmsi_pkg;
   // register addresses on the serial port
   localparam logic [7:0] HMSI_ADDR_EVENT_STATUS = 8'he8;
   localparam logic [7:0] HMSI_ADDR_EVENT_MASK = 8'he9;
   localparam int HMSI_EVENT_W = 8;
   localparam logic [7:0] HMSI_STATUS_RESET = 8'h00;
   localparam logic [7:0] HMSI_MASK_RESET = 8'h00;
   localparam logic [7:0] HMSI_READ_UNMAPPED = 8'h00;
   // clock and init timing
   localparam int HMSI_CLOCK_MHZ = 250;
   localparam int HMSI_INIT_TYP_MS = 3;
   localparam int HMSI_INIT_MAX_MS = 4;
   localparam int HMSI_INIT_CYCLES = HMSI_INIT_TYP_MS * 1000 * HMSI_CLOCK_MHZ;
   localparam int HMSI_INIT_MAX_CYCLES = HMSI_INIT_MAX_MS * 1000 * HMSI_CLOCK_MHZ;
   localparam int HMSI_CNT_W = 32;
   // reference frequency codes in kHz
   localparam int HMSI_FREQ_W = 16;
   localparam logic [15:0] HMSI_KHZ_38M4 = 16'h9600;
   localparam logic [15:0] HMSI_KHZ_26M0 = 16'h6590;
   localparam logic [15:0] HMSI_KHZ_19M2 = 16'h4b00;
   localparam logic [15:0] HMSI_KHZ_12M0 = 16'h2ee0;
   localparam logic [15:0] HMSI_KHZ_24M0 = 16'h5dc0;
   localparam logic [15:0] HMSI_KHZ_27M0 = 16'h6978;
   localparam logic [15:0] HMSI_KHZ_25M0 = 16'h61a8;
   localparam logic [15:0] HMSI_KHZ_50M0 = 16'hc350;
   localparam logic [1:0] HMSI_SEL_00 = 2'h0;
   localparam logic [1:0] HMSI_SEL_01 = 2'h1;
   localparam logic [1:0] HMSI_SEL_10 = 2'h2;
   typedef enum logic [1:0] {
      HMSI_ST_STANDBY = 2'b00,
      HMSI_ST_INIT = 2'b01,
      HMSI_ST_RUN = 2'b10
   } hmsi_state_t;
endpackage

// ---- hw/hmsi_evt_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface hmsi_evt_if #(parameter int W = 8);
   logic [W-1:0] cond;
   logic [W-1:0] clear;
   logic clear_enable;
   logic [W-1:0] status;
   modport latch (input cond, input clear, input clear_enable, output status);
   modport user (output cond, output clear, output clear_enable, input status);
endinterface
`default_nettype wire

// ---- hw/hmsi_evt_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
module hmsi_evt_latch #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic run,
   hmsi_evt_if.latch evt
);
   import hmsi_pkg::*;
   logic [W-1:0] status_reg, status_next;
   logic [W-1:0] prev_reg, prev_next;
   logic [W-1:0] rise;

   always_comb begin
      rise = evt.cond & ~prev_reg;
      prev_next = run ? evt.cond : '0;
      status_next = status_reg;
      if (evt.clear_enable) begin
         status_next = status_reg & ~evt.clear;
      end
      // only a fresh rising edge sets
      status_next = status_next | (rise & {W{run}});
      if (!run) begin
         status_next = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         status_reg <= '0;
         prev_reg <= '0;
      end else begin
         status_reg <= status_next;
         prev_reg <= prev_next;
      end
   end

   assign evt.status = status_reg;
endmodule
`default_nettype wire

// ---- hw/hmsi_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - logic uses rising reference edges only
// - pin high selects primary frequency table
// - pin low selects secondary frequency table
// - interrupt pin open-drain, active low
// - status bits latch until software clears
// - bits re-set only on new events
// - status register plus mask gates pin
// - suspend option gives direct level instead
// - low when unconfigured or suspended
// - reset low standby, high hub mode
// - standby keeps no configuration state
// - reset clears everything, halts pll
// - load rom defaults during init
// - init enables regulator, locks, latches straps
// - init exits on its own timer
// - init typically 3ms, at most 4ms
// - serial port ignored during init
module hmsi_top #(
   parameter int INIT_CYCLES = hmsi_pkg::HMSI_INIT_CYCLES,
   parameter logic [7:0] ROM_MASK_DEFAULT = hmsi_pkg::HMSI_MASK_RESET
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [1:0] ref_sel,
   input wire logic int_n_in,
   output logic int_n_out,
   output logic int_n_oe,
   input wire logic [hmsi_pkg::HMSI_EVENT_W-1:0] event_cond,
   input wire logic suspend_level_select,
   input wire logic hub_configured,
   input wire logic hub_suspended,
   input wire logic pll_lock,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_ack,
   output logic regulator_en,
   output logic pll_enable,
   output logic logic_reset,
   output logic ports_enable,
   output logic init_done,
   output logic [hmsi_pkg::HMSI_FREQ_W-1:0] ref_khz,
   output logic ref_table_secondary,
   output logic [1:0] ref_sel_latched
);
   import hmsi_pkg::*;

   function automatic logic [HMSI_FREQ_W-1:0] freq_of(input logic secondary, input logic [1:0] sel);
      logic [HMSI_FREQ_W-1:0] f;
      f = '0;
      if (!secondary) begin
         case (sel)
            HMSI_SEL_00: f = HMSI_KHZ_38M4;
            HMSI_SEL_01: f = HMSI_KHZ_26M0;
            HMSI_SEL_10: f = HMSI_KHZ_19M2;
            default: f = HMSI_KHZ_12M0;
         endcase
      end else begin
         case (sel)
            HMSI_SEL_00: f = HMSI_KHZ_24M0;
            HMSI_SEL_01: f = HMSI_KHZ_27M0;
            HMSI_SEL_10: f = HMSI_KHZ_25M0;
            default: f = HMSI_KHZ_50M0;
         endcase
      end
      return f;
   endfunction

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // mode sequencing
   hmsi_state_t state_reg, state_next;
   logic [HMSI_CNT_W-1:0] cnt_reg, cnt_next;
   logic secondary_reg, secondary_next;
   logic [1:0] sel_reg, sel_next;
   logic run;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      secondary_next = secondary_reg;
      sel_next = sel_reg;
      case (state_reg)
         HMSI_ST_STANDBY: begin
            cnt_next = '0;
            state_next = HMSI_ST_INIT;
         end
         HMSI_ST_INIT: begin
            // straps latched during init, last sample kept
            // host holds pin low across init for secondary
            secondary_next = ~int_n_in;
            sel_next = ref_sel;
            cnt_next = cnt_reg + 1'b1;
            // count set from typical time, below maximum
            if (cnt_reg >= HMSI_CNT_W'(INIT_CYCLES - 1)) begin
               state_next = HMSI_ST_RUN;
            end
         end
         HMSI_ST_RUN: begin
            state_next = HMSI_ST_RUN;
         end
         default: begin
            state_next = HMSI_ST_STANDBY;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      // reset drops all state at once
      if (!reset_n) begin
         state_reg <= HMSI_ST_STANDBY;
         cnt_reg <= '0;
         secondary_reg <= 1'b0;
         sel_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         secondary_reg <= secondary_next;
         sel_reg <= sel_next;
      end
   end

   assign run = (state_reg == HMSI_ST_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // event latch and mask
   hmsi_evt_if #(.W(HMSI_EVENT_W)) evt ();
   logic [7:0] mask_reg, mask_next;
   logic [7:0] rdata_reg, rdata_next;
   logic ack_reg, ack_next;
   logic wr_status, wr_mask;
   logic int_active_reg, int_active_next;
   logic [HMSI_FREQ_W-1:0] khz_reg, khz_next;

   assign wr_status = run && reg_wr && addr_hit(reg_addr, HMSI_ADDR_EVENT_STATUS);
   assign wr_mask = run && reg_wr && addr_hit(reg_addr, HMSI_ADDR_EVENT_MASK);

   assign evt.cond = event_cond;
   assign evt.clear = reg_wdata;
   assign evt.clear_enable = wr_status;

   hmsi_evt_latch #(.W(HMSI_EVENT_W)) u_latch (
      .clock(clock),
      .reset_n(reset_n),
      .run(run),
      .evt(evt)
   );

   always_comb begin
      mask_next = mask_reg;
      rdata_next = rdata_reg;
      ack_next = 1'b0;
      // rom default for mask loaded during init
      if (state_reg == HMSI_ST_INIT) begin
         mask_next = ROM_MASK_DEFAULT;
      end
      // mask register, write one to enable
      if (wr_mask) begin
         mask_next = reg_wdata;
      end
      if (run && (reg_wr || reg_rd)) begin
         ack_next = 1'b1;
      end
      if (run && reg_rd) begin
         if (addr_hit(reg_addr, HMSI_ADDR_EVENT_STATUS)) begin
            rdata_next = evt.status;
         end else if (addr_hit(reg_addr, HMSI_ADDR_EVENT_MASK)) begin
            rdata_next = mask_reg;
         end else begin
            rdata_next = HMSI_READ_UNMAPPED;
         end
      end
      if (suspend_level_select) begin
         int_active_next = run && (!hub_configured || hub_suspended);
      end else begin
         int_active_next = run && |(evt.status & mask_reg);
      end
      khz_next = freq_of(secondary_reg, sel_reg);
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mask_reg <= HMSI_MASK_RESET;
         rdata_reg <= HMSI_READ_UNMAPPED;
         ack_reg <= 1'b0;
         int_active_reg <= 1'b0;
         khz_reg <= '0;
      end else begin
         mask_reg <= mask_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         int_active_reg <= int_active_next;
         khz_reg <= khz_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   // open drain, never drives high
   assign int_n_out = 1'b0;
   assign int_n_oe = int_active_reg;
   assign reg_rdata = rdata_reg;
   assign reg_ack = ack_reg;
   // regulator and pll up from init onward, pll left to lock
   assign regulator_en = (state_reg != HMSI_ST_STANDBY);
   // pll halted and ports off while in reset
   assign pll_enable = (state_reg != HMSI_ST_STANDBY);
   assign logic_reset = (state_reg != HMSI_ST_RUN);
   assign ports_enable = run && pll_lock;
   assign init_done = run;
   assign ref_khz = khz_reg;
   assign ref_table_secondary = secondary_reg;
   assign ref_sel_latched = sel_reg;
endmodule
`default_nettype wire

// ---- verification/hmsi_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module hmsi_properties #(
   parameter int INIT_CYCLES = 20
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic reg_rd,
   input wire logic int_n_out,
   input wire logic int_n_oe,
   input wire logic suspend_level_select,
   input wire logic hub_configured,
   input wire logic hub_suspended,
   input wire logic reg_ack,
   input wire logic regulator_en,
   input wire logic init_done
);
   int cnt_reg;
   int cnt_next;
   logic sls;
   logic asleep;
   assign sls = init_done && suspend_level_select;
   assign asleep = !hub_configured || hub_suspended;
   // counts samples spent in init
   always_comb begin
      cnt_next = (regulator_en && !init_done) ? cnt_reg + 1 : 0;
   end
   always_ff @(posedge clock) begin
      cnt_reg <= reset_n ? cnt_next : 0;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   property p_od;
      int_n_out == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("pin driven high");
   property p_standby;
      reset_n && !$past(reset_n) |-> !regulator_en && !init_done && !int_n_oe;
   endproperty
   a_standby: assert property (p_standby) else $error("standby not clean");
   property p_init_len;
      $rose(init_done) |-> cnt_reg == INIT_CYCLES;
   endproperty
   a_init_len: assert property (p_init_len) else $error("init length");
   property p_no_ack;
      !init_done |=> !reg_ack;
   endproperty
   a_no_ack: assert property (p_no_ack) else $error("ack outside run");
   property p_ack;
      reg_rd && init_done |=> reg_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("read not acked");
   property p_quiet;
      !init_done |-> !int_n_oe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("pin driven in init");
   property p_susp_low;
      sls && asleep ##1 sls |-> int_n_oe;
   endproperty
   a_susp_low: assert property (p_susp_low) else $error("suspend low");
   property p_susp_high;
      sls && !asleep ##1 sls |-> !int_n_oe;
   endproperty
   a_susp_high: assert property (p_susp_high) else $error("active high");
endmodule
bind hmsi_top hmsi_properties #(.INIT_CYCLES(INIT_CYCLES)) hmsi_properties_i (
   .clock(clock),
   .reset_n(reset_n),
   .reg_rd(reg_rd),
   .int_n_out(int_n_out),
   .int_n_oe(int_n_oe),
   .suspend_level_select(suspend_level_select),
   .hub_configured(hub_configured),
   .hub_suspended(hub_suspended),
   .reg_ack(reg_ack),
   .regulator_en(regulator_en),
   .init_done(init_done)
);
`default_nettype wire

// ---- verification/hmsi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hmsi_host_model (
   input wire logic strap_low,
   input wire logic int_n_oe,
   input wire logic int_n_out,
   output logic int_wire
);
   // host strap drive
   // pull-up wins once both parties let go
   assign int_wire = (strap_low || (int_n_oe && !int_n_out)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- verification/hub_mode_startup_and_irq_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module hub_mode_startup_and_irq_test;
   import hmsi_pkg::*;
   logic clock = 0;
   logic reset_n = 0;
   logic strap_low = 0;
   logic sls = 0;
   logic hcfg = 0;
   logic hsus = 0;
   logic wr = 0;
   logic rd = 0;
   logic [1:0] sel = 0;
   logic [7:0] cond = 0;
   logic [7:0] addr = 0;
   logic [7:0] wdata = 0;
   logic [7:0] rdata;
   logic int_wire, oe, out, ack, done, sec, pe;
   logic [15:0] khz;
   int error_cnt = 0;
   int checks = 0;
   localparam logic [15:0] khz_tab [8] = '{16'h9600, 16'h6590, 16'h4b00, 16'h2ee0,
      16'h5dc0, 16'h6978, 16'h61a8, 16'hc350};
   always #2 clock = ~clock;
   hmsi_top #(.INIT_CYCLES(20)) hmsi_top_i (.clock(clock), .reset_n(reset_n), .ref_sel(sel),
      .int_n_in(int_wire), .int_n_out(out), .int_n_oe(oe), .event_cond(cond),
      .suspend_level_select(sls), .hub_configured(hcfg), .hub_suspended(hsus), .pll_lock(1'b1),
      .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
      .reg_ack(ack), .regulator_en(), .pll_enable(), .logic_reset(), .ports_enable(pe),
      .init_done(done), .ref_khz(khz), .ref_table_secondary(sec), .ref_sel_latched());
   hmsi_host_model hmsi_host_model_i (.strap_low(strap_low), .int_n_oe(oe), .int_n_out(out),
      .int_wire(int_wire));
   ////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one strobe, answer seen one cycle later
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic ea,
      input logic [7:0] exp);
      @(negedge clock);
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(negedge clock);
      wr = 0;
      rd = 0;
      chk({15'h0, ack}, {15'h0, ea});
      if (!w) chk({8'h0, rdata}, {8'h0, exp});
   endtask
   task automatic t_boot(input logic low, input logic [1:0] s);
      @(negedge clock);
      reset_n = 0;
      strap_low = low;
      sel = s;
      repeat (6) @(negedge clock);
      reset_n = 1;
      acc(0, 8'he8, 0, 0, 0);
      repeat (25) @(negedge clock);
      strap_low = 0;
      repeat (2) @(negedge clock);
      chk(khz, khz_tab[{low, s}]);
      chk({15'h0, sec}, {15'h0, low});
      chk({15'h0, pe}, 16'h1);
      acc(0, 8'he9, 0, 1, 8'h00);
   endtask
   task automatic t_irq;
      acc(1, 8'he9, 8'h01, 1, 0);
      acc(0, 8'h55, 0, 1, 8'h00);
      cond = 8'h03;
      repeat (3) @(negedge clock);
      chk({15'h0, int_wire}, 16'h0);
      cond = 0;
      repeat (2) @(negedge clock);
      chk({15'h0, int_wire}, 16'h0);
      acc(0, 8'he8, 0, 1, 8'h03);
      cond = 8'h01;
      acc(1, 8'he8, 8'h03, 1, 0);
      repeat (2) @(negedge clock);
      chk({15'h0, int_wire}, 16'h1);
      acc(0, 8'he8, 0, 1, 8'h00);
      cond = 0;
      @(negedge clock);
      cond = 8'h01;
      repeat (3) @(negedge clock);
      chk({15'h0, int_wire}, 16'h0);
   endtask
   // pending event left set on purpose: level mode must hide it
   task automatic t_susp;
      sls = 1;
      hcfg = 1;
      repeat (3) @(negedge clock);
      chk({15'h0, int_wire}, 16'h1);
      hsus = 1;
      repeat (2) @(negedge clock);
      chk({15'h0, int_wire}, 16'h0);
      hsus = 0;
      hcfg = 0;
      repeat (2) @(negedge clock);
      chk({15'h0, int_wire}, 16'h0);
   endtask
   initial begin
      for (int i = 0; i < 8; i++) t_boot(i[2], i[1:0]);
      t_irq;
      t_susp;
      t_boot(0, 2'h1);
      conclude;
   end
   initial begin
      #20000;
      error_cnt++;
      conclude;
   end
endmodule
`default_nettype wire
